// ### shared/tmac_pkg.sv
package tmac_pkg;
	// ************************************************************
	// Widths and control bit positions
	// ************************************************************
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int CTRL_W = 32;
	localparam int CTRL_DMEM_EN_BIT = 16;
	localparam int CTRL_DMEM_LOAD_BIT = 17;
	localparam int CTRL_IMEM_EN_BIT = 18;
	localparam int CTRL_IMEM_LOAD_BIT = 19;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] IMEM_BASE = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ZERO_ADDR = 32'h0000_0000;
	// ************************************************************
	// Memory port arbitration states
	// ************************************************************
	typedef enum logic [2:0] {
		TMAC_IDLE = 3'h1,
		TMAC_WRITE = 3'h2,
		TMAC_DEFER = 3'h4
	} tmac_port_type;
endpackage

// ### shared/tmac_mem_if.sv
`timescale 1ns/1ps
interface tmac_mem_if #(parameter int AW = 32, parameter int DW = 32);
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl(output en, output we, output addr, output wdata,
		input rdata);
	modport mem(input en, input we, input addr, input wdata,
		output rdata);
endinterface

// ### rtl/tmac_imem_port.sv
`timescale 1ns/1ps
module tmac_imem_port (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Requests
	input wire logic fetch_req,
	input wire logic [tmac_pkg::ADDR_W-1:0] fetch_addr,
	input wire logic dread_req,
	input wire logic dwrite_req,
	input wire logic [tmac_pkg::ADDR_W-1:0] data_addr,
	input wire logic [tmac_pkg::DATA_W-1:0] data_wdata,
	// Result
	output logic stall,
	output logic fetch_served,
	// Memory
	tmac_mem_if.ctrl mem
);
	import tmac_pkg::*;

	// ************************************************************
	// Single port arbitration
	// ************************************************************
	tmac_port_type state_ff, nxt_state;
	logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [ADDR_W-1:0] held_ff, nxt_held;

	always_comb begin
		nxt_state = TMAC_IDLE;
		nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;
		nxt_held = held_ff;
		stall = 1'b0;
		fetch_served = 1'b0;
		mem.en = 1'b0;
		mem.we = 1'b0;
		mem.addr = ZERO_ADDR;
		mem.wdata = wdata_ff;
		case (state_ff)
			TMAC_WRITE: begin
				// Write address pipelined in line with data
				mem.en = 1'b1;
				mem.we = 1'b1;
				mem.addr = waddr_ff;
				if (fetch_req || dread_req || dwrite_req) begin
					stall = 1'b1;
				end
			end
			TMAC_DEFER: begin
				// Deferred fetch served after a data read, or before a write held over the stall
				mem.en = 1'b1;
				mem.addr = held_ff;
				fetch_served = 1'b1;
				// Write held over the stall is taken now
				if (dwrite_req) begin
					nxt_state = TMAC_WRITE;
					nxt_waddr = data_addr;
					nxt_wdata = data_wdata;
				end
			end
			default: begin
				if (dwrite_req && fetch_req) begin
					// One stall, fetch first, then the write
					stall = 1'b1;
					nxt_state = TMAC_DEFER;
					nxt_held = fetch_addr;
				end else if (dwrite_req) begin
					nxt_state = TMAC_WRITE;
					nxt_waddr = data_addr;
					nxt_wdata = data_wdata;
				end else if (dread_req) begin
					mem.en = 1'b1;
					mem.addr = data_addr;
					if (fetch_req) begin
						stall = 1'b1;
						nxt_state = TMAC_DEFER;
						nxt_held = fetch_addr;
					end
				end else if (fetch_req) begin
					mem.en = 1'b1;
					mem.addr = fetch_addr;
					fetch_served = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= TMAC_IDLE;
			waddr_ff <= ZERO_ADDR;
			wdata_ff <= '0;
			held_ff <= ZERO_ADDR;
		end else begin
			state_ff <= nxt_state;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
			held_ff <= nxt_held;
		end
	end

	a_defer_one_cycle: assert property (
		@(posedge mclk) disable iff (!arst_n)
		state_ff == TMAC_IDLE && dread_req && !dwrite_req && fetch_req
		|=> state_ff == TMAC_DEFER ##1 state_ff != TMAC_DEFER)
		else $error("collision stall not one cycle");
	a_write_pipelined: assert property (
		@(posedge mclk) disable iff (!arst_n)
		dwrite_req && (state_ff == TMAC_DEFER
		|| state_ff == TMAC_IDLE && !fetch_req)
		|=> mem.we && mem.addr == $past(data_addr))
		else $error("write not issued next cycle");
	a_deferred_addr: assert property (
		@(posedge mclk) disable iff (!arst_n)
		state_ff == TMAC_DEFER |-> mem.addr == $past(fetch_addr))
		else $error("deferred fetch address lost");
endmodule

// ### rtl/tmac_top.sv
`timescale 1ns/1ps
// Behaviour
// - Instruction load mode blocks data reads from instruction memory.
// - Writes in instruction range update instruction memory when bit 18 is set, load mode or not.
// - Control bit 16 set routes data range accesses to data memory.
// - Control bit 16 clear sends data range accesses to the bus.
// - Data accesses to instruction range follow instruction enable.
// - Data load mode blocks reads from data memory.
// - Writes in data range update data memory when bit 16 is set, load mode or not.
// - Boot enable at soft reset leaves instruction memory enabled.
// - After boot reset visible instruction size equals physical size.
// - Boot enable leaves data memory disabled after reset.
// - Data memory stalls only behind a completing write.
// - Instruction memory decoded at address zero, single port.
// - Protection permissions apply when protection unit enabled.
// - Instruction memory serves fetches and data accesses.
// - Instruction fetches single cycle unless a data access to instruction memory arrives in the same cycle or a write is completing.
// - Bit 18 enables instruction memory; clear sends fetches to bus.
// - Same-cycle fetch and data read stall exactly one cycle.
module tmac_top #(
	parameter int IMEM_LOG2 = 16,
	parameter int DMEM_LOG2 = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Control
	input wire logic [tmac_pkg::CTRL_W-1:0] ctrl_wdata,
	input wire logic ctrl_we,
	output logic [tmac_pkg::CTRL_W-1:0] ctrl_rdata,
	input wire logic boot_from_tight_memory,
	input wire logic soft_reset,
	input wire logic [tmac_pkg::ADDR_W-1:0] dmem_base,
	input wire logic [4:0] imem_vis_log2_in,
	input wire logic imem_vis_we,
	output logic [4:0] imem_vis_log2,
	input wire logic prot_enable,
	input wire logic prot_fetch_ok,
	input wire logic prot_data_ok,
	// Core instruction side
	input wire logic fetch_req,
	input wire logic [tmac_pkg::ADDR_W-1:0] fetch_addr,
	output logic [tmac_pkg::DATA_W-1:0] fetch_rdata,
	output logic fetch_to_bus,
	output logic fetch_abort,
	// Core data side
	input wire logic data_req,
	input wire logic data_write,
	input wire logic [tmac_pkg::ADDR_W-1:0] data_addr,
	input wire logic [tmac_pkg::DATA_W-1:0] data_wdata,
	output logic [tmac_pkg::DATA_W-1:0] data_rdata,
	output logic data_to_bus,
	output logic data_abort,
	output logic core_stall,
	// Instruction memory
	output logic imem_en,
	output logic imem_we,
	output logic [tmac_pkg::ADDR_W-1:0] imem_addr,
	output logic [tmac_pkg::DATA_W-1:0] imem_wdata,
	input wire logic [tmac_pkg::DATA_W-1:0] imem_rdata,
	// Data memory
	output logic dmem_en,
	output logic dmem_we,
	output logic [tmac_pkg::ADDR_W-1:0] dmem_addr,
	output logic [tmac_pkg::DATA_W-1:0] dmem_wdata,
	input wire logic [tmac_pkg::DATA_W-1:0] dmem_rdata
);
	import tmac_pkg::*;

	// ************************************************************
	// Control register
	// ************************************************************
	logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [4:0] vis_ff, nxt_vis;
	logic boot_ff, nxt_boot;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_vis = vis_ff;
		nxt_boot = boot_ff;
		if (soft_reset) begin
			nxt_boot = boot_from_tight_memory;
			nxt_ctrl = CTRL_RESET;
		end else if (boot_ff) begin
			nxt_boot = 1'b0;
			// Boot strap enables instruction memory only
			nxt_ctrl[CTRL_IMEM_EN_BIT] = 1'b1;
			nxt_vis = 5'(IMEM_LOG2);
		end else begin
			if (ctrl_we) begin
				nxt_ctrl = ctrl_wdata;
			end
			if (imem_vis_we) begin
				nxt_vis = imem_vis_log2_in;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= CTRL_RESET;
			vis_ff <= 5'h00;
			boot_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			vis_ff <= nxt_vis;
			boot_ff <= nxt_boot;
		end
	end

	assign ctrl_rdata = ctrl_ff;
	assign imem_vis_log2 = vis_ff;

	logic i_en, i_load, d_en, d_load;
	assign i_en = ctrl_ff[CTRL_IMEM_EN_BIT];
	assign i_load = ctrl_ff[CTRL_IMEM_LOAD_BIT];
	assign d_en = ctrl_ff[CTRL_DMEM_EN_BIT];
	assign d_load = ctrl_ff[CTRL_DMEM_LOAD_BIT];

	// ************************************************************
	// Address decode
	// ************************************************************
	logic [ADDR_W-1:0] i_mask, d_mask;
	logic f_in_i, d_in_i, d_in_d;
	assign i_mask = ~((ADDR_W'(1) << vis_ff) - ADDR_W'(1));
	assign d_mask = ~((ADDR_W'(1) << DMEM_LOG2) - ADDR_W'(1));
	// Instruction memory sits at address zero
	assign f_in_i = (fetch_addr & i_mask) == IMEM_BASE;
	assign d_in_i = (data_addr & i_mask) == IMEM_BASE;
	assign d_in_d = (data_addr & d_mask) == (dmem_base & d_mask);

	logic f_tcm, di_rd, di_wr, dd_rd, dd_wr;
	logic f_perm, d_perm;
	// Permissions only checked with protection on
	assign f_perm = !prot_enable || prot_fetch_ok;
	assign d_perm = !prot_enable || prot_data_ok;
	assign f_tcm = fetch_req && i_en && f_in_i && f_perm;
	// Load mode blocks reads only
	assign di_rd = data_req && !data_write && i_en && !i_load && d_in_i
		&& d_perm;
	assign di_wr = data_req && data_write && i_en && d_in_i
		&& d_perm;
	assign dd_rd = data_req && !data_write && d_en && !d_load && d_in_d
		&& !d_in_i && d_perm;
	assign dd_wr = data_req && data_write && d_en && d_in_d
		&& !d_in_i && d_perm;

	assign fetch_abort = fetch_req && !f_perm;
	assign data_abort = data_req && !d_perm;
	assign fetch_to_bus = fetch_req && f_perm && !f_tcm;
	assign data_to_bus = data_req && d_perm
		&& !(di_rd || di_wr || dd_rd || dd_wr);

	// ************************************************************
	// Instruction memory port
	// ************************************************************
	tmac_mem_if #(.AW(ADDR_W), .DW(DATA_W)) ibus();
	logic i_stall, i_fetch_served;

	tmac_imem_port u_iport (
		.mclk(mclk),
		.arst_n(arst_n),
		.fetch_req(f_tcm),
		.fetch_addr(fetch_addr),
		.dread_req(di_rd),
		.dwrite_req(di_wr),
		.data_addr(data_addr),
		.data_wdata(data_wdata),
		.stall(i_stall),
		.fetch_served(i_fetch_served),
		.mem(ibus.ctrl)
	);

	assign imem_en = ibus.en;
	assign imem_we = ibus.we;
	assign imem_addr = ibus.addr;
	assign imem_wdata = ibus.wdata;
	assign ibus.rdata = imem_rdata;

	// ************************************************************
	// Data memory port: write pipelined one cycle
	// ************************************************************
	logic dw_pend_ff, nxt_dw_pend;
	logic [ADDR_W-1:0] dw_addr_ff, nxt_dw_addr;
	logic [DATA_W-1:0] dw_data_ff, nxt_dw_data;
	logic d_stall;

	always_comb begin
		nxt_dw_pend = dd_wr;
		nxt_dw_addr = dd_wr ? data_addr : dw_addr_ff;
		nxt_dw_data = dd_wr ? data_wdata : dw_data_ff;
		// Only a completing write blocks the next access
		d_stall = dw_pend_ff && (dd_rd || dd_wr);
		if (d_stall) begin
			nxt_dw_pend = 1'b0;
		end
		dmem_en = dw_pend_ff || dd_rd;
		dmem_we = dw_pend_ff;
		dmem_addr = dw_pend_ff ? dw_addr_ff : data_addr;
		dmem_wdata = dw_data_ff;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dw_pend_ff <= 1'b0;
			dw_addr_ff <= ZERO_ADDR;
			dw_data_ff <= '0;
		end else begin
			dw_pend_ff <= nxt_dw_pend;
			dw_addr_ff <= nxt_dw_addr;
			dw_data_ff <= nxt_dw_data;
		end
	end

	assign core_stall = i_stall || d_stall;

	// ************************************************************
	// Read data return, one cycle after the address
	// ************************************************************
	logic rd_i_ff, rd_d_ff, rf_ff;
	logic nxt_rd_i, nxt_rd_d, nxt_rf;
	always_comb begin
		// Port read for data, also when a fetch is deferred
		nxt_rd_i = ibus.en && !ibus.we && !i_fetch_served;
		nxt_rd_d = dd_rd && !d_stall;
		nxt_rf = i_fetch_served;
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_i_ff <= 1'b0;
			rd_d_ff <= 1'b0;
			rf_ff <= 1'b0;
		end else begin
			rd_i_ff <= nxt_rd_i;
			rd_d_ff <= nxt_rd_d;
			rf_ff <= nxt_rf;
		end
	end
	// Memory answers in one cycle
	assign fetch_rdata = rf_ff ? imem_rdata : '0;
	assign data_rdata = rd_i_ff ? imem_rdata : (rd_d_ff ? dmem_rdata : '0);

	// ************************************************************
	// Checks
	// ************************************************************
	a_iload_no_read: assert property (
		@(posedge mclk) disable iff (!arst_n)
		data_req && !data_write && i_load && d_in_i
		|-> !di_rd && (data_to_bus || data_abort))
		else $error("instruction memory read in load mode");
	a_dload_no_read: assert property (
		@(posedge mclk) disable iff (!arst_n)
		data_req && !data_write && d_load
		|-> !dd_rd && (!d_in_d || di_rd || data_to_bus || data_abort))
		else $error("data memory read in load mode");
	a_dmem_routing: assert property (
		@(posedge mclk) disable iff (!arst_n)
		data_req && d_perm && d_in_d && !d_in_i && !d_en |-> data_to_bus)
		else $error("disabled data memory not routed to bus");
	a_dwrite_lands: assert property (
		@(posedge mclk) disable iff (!arst_n)
		dd_wr && !d_stall |=> dmem_we && dmem_addr == $past(data_addr))
		else $error("data memory write lost");
	a_boot_enable: assert property (
		@(posedge mclk) disable iff (!arst_n)
		soft_reset && boot_from_tight_memory ##1 !soft_reset
		|=> i_en && !d_en && vis_ff == 5'(IMEM_LOG2))
		else $error("boot did not enable instruction memory");
	a_fetch_off_bus: assert property (
		@(posedge mclk) disable iff (!arst_n)
		fetch_req && f_perm && !i_en |-> fetch_to_bus)
		else $error("fetch not sent to bus when disabled");
endmodule

// ### tb/tmac_sram_model.sv
`timescale 1ns/1ps
module tmac_sram_model (
	// Clock
	input wire logic mclk,
	// Memory port
	input wire logic en,
	input wire logic we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	logic [31:0] mem [0:1023];
	initial rdata = 32'h0;
	// ************************************************************
	// Single port, one-cycle read, contents kept through reset
	// ************************************************************
	always @(posedge mclk) begin
		if (en && we) begin
			mem[addr[11:2]] <= wdata;
			rdata <= ~rdata;
		end else if (en) begin
			rdata <= mem[addr[11:2]];
		end else begin
			rdata <= ~rdata;
		end
	end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
	import tmac_pkg::*;
	localparam int LOG2 = 12;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic ctrl_we = 1'b0;
	logic boot_from_tight_memory = 1'b0;
	logic soft_reset = 1'b0;
	logic prot_enable = 1'b0;
	logic prot_data_ok = 1'b1;
	logic prot_fetch_ok = 1'b1;
	logic fetch_req = 1'b0;
	logic data_req = 1'b0;
	logic data_write = 1'b0;
	logic [31:0] ctrl_wdata = 32'h0;
	logic [31:0] dmem_base = 32'h0001_0000;
	logic [31:0] fetch_addr = 32'h0;
	logic [31:0] data_addr = 32'h0;
	logic [31:0] data_wdata = 32'h0;
	logic [31:0] ctrl_rdata, fetch_rdata, data_rdata, imem_rdata, dmem_rdata;
	logic [31:0] imem_addr, imem_wdata, dmem_addr, dmem_wdata;
	logic [4:0] imem_vis_log2;
	logic fetch_to_bus, fetch_abort, data_to_bus, data_abort, core_stall;
	logic imem_en, imem_we, dmem_en, dmem_we;
	int num_errors = 0;
	int checked = 0;
	always #25 mclk = ~mclk;
	tmac_top #(.IMEM_LOG2(LOG2), .DMEM_LOG2(LOG2)) dut (.mclk, .arst_n,
		.ctrl_wdata, .ctrl_we, .ctrl_rdata, .boot_from_tight_memory,
		.soft_reset, .dmem_base, .imem_vis_log2_in(5'h0),
		.imem_vis_we(1'b0), .imem_vis_log2, .prot_enable,
		.prot_fetch_ok, .prot_data_ok, .fetch_req, .fetch_addr,
		.fetch_rdata, .fetch_to_bus, .fetch_abort, .data_req, .data_write,
		.data_addr, .data_wdata, .data_rdata, .data_to_bus, .data_abort,
		.core_stall, .imem_en, .imem_we, .imem_addr, .imem_wdata,
		.imem_rdata, .dmem_en, .dmem_we, .dmem_addr, .dmem_wdata,
		.dmem_rdata);
	tmac_sram_model imem (.mclk, .en(imem_en), .we(imem_we),
		.addr(imem_addr), .wdata(imem_wdata), .rdata(imem_rdata));
	tmac_sram_model dmem (.mclk, .en(dmem_en), .we(dmem_we),
		.addr(dmem_addr), .wdata(dmem_wdata), .rdata(dmem_rdata));
	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic conclude;
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask
	task automatic wctrl(input logic [31:0] v);
		ctrl_wdata = v;
		ctrl_we = 1'b1;
		@(negedge mclk);
		ctrl_we = 1'b0;
		chk("ctrl_rdata", v, ctrl_rdata);
	endtask
	task automatic idle;
		fetch_req = 1'b0;
		data_req = 1'b0;
		@(negedge mclk);
	endtask
	// Request stays up after return so that calls can run back to back
	task automatic dacc(input logic w, input logic [31:0] a, d,
		input logic bus, input int st);
		int n;
		n = 0;
		data_req = 1'b1;
		data_write = w;
		data_addr = a;
		data_wdata = d;
		#1;
		while (core_stall === 1'b1 && n < 8) begin
			@(negedge mclk);
			n++;
		end
		chk("data_to_bus", {31'h0, bus}, {31'h0, data_to_bus});
		if (st >= 0) chk("stall_cycles", st, n);
		@(negedge mclk);
		if (!w && !bus) chk("data_rdata", d, data_rdata);
	endtask
	task automatic facc(input logic [31:0] a, d, input logic bus);
		fetch_req = 1'b1;
		fetch_addr = a;
		#1;
		chk("fetch_to_bus", {31'h0, bus}, {31'h0, fetch_to_bus});
		@(negedge mclk);
		if (!bus) chk("fetch_rdata", d, fetch_rdata);
	endtask
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (4) @(negedge mclk);
		arst_n = 1'b1;
		chk("ctrl_rdata", 32'h0, ctrl_rdata);
		chk("imem_vis_log2", 32'h0, {27'h0, imem_vis_log2});
		soft_reset = 1'b1;
		boot_from_tight_memory = 1'b1;
		repeat (2) @(negedge mclk);
		soft_reset = 1'b0;
		repeat (2) @(negedge mclk);
		chk("ctrl_rdata", 32'h0004_0000, ctrl_rdata);
		chk("imem_vis_log2", LOG2, {27'h0, imem_vis_log2});
		dacc(1'b1, 32'h10, 32'ha5a5_0010, 1'b0, 0);
		dacc(1'b1, 32'h14, 32'ha5a5_0014, 1'b0, -1);
		dacc(1'b0, 32'h10, 32'ha5a5_0010, 1'b0, 1);
		idle();
		facc(32'h10, 32'ha5a5_0010, 1'b0);
		idle();
		fetch_req = 1'b1;
		fetch_addr = 32'h10;
		data_req = 1'b1;
		data_write = 1'b0;
		data_addr = 32'h14;
		#1;
		chk("core_stall", 32'h1, {31'h0, core_stall});
		@(negedge mclk);
		chk("core_stall", 32'h0, {31'h0, core_stall});
		chk("data_rdata", 32'ha5a5_0014, data_rdata);
		@(negedge mclk);
		chk("fetch_rdata", 32'ha5a5_0010, fetch_rdata);
		// Fetch and write in the same cycle: one stall, write lands
		data_write = 1'b1;
		data_addr = 32'h18;
		data_wdata = 32'ha5a5_0018;
		#1;
		chk("core_stall", 32'h1, {31'h0, core_stall});
		@(negedge mclk);
		chk("core_stall", 32'h0, {31'h0, core_stall});
		@(negedge mclk);
		chk("fetch_rdata", 32'ha5a5_0010, fetch_rdata);
		fetch_req = 1'b0;
		dacc(1'b0, 32'h18, 32'ha5a5_0018, 1'b0, 1);
		idle();
		wctrl(32'h000c_0000);
		dacc(1'b1, 32'h20, 32'h5a5a_0020, 1'b0, 0);
		dacc(1'b0, 32'h20, 32'h0, 1'b1, -1);
		idle();
		wctrl(32'h0004_0000);
		dacc(1'b0, 32'h20, 32'h5a5a_0020, 1'b0, 0);
		prot_enable = 1'b1;
		prot_data_ok = 1'b0;
		prot_fetch_ok = 1'b0;
		fetch_req = 1'b1;
		fetch_addr = 32'h10;
		#1;
		chk("data_abort", 32'h1, {31'h0, data_abort});
		chk("fetch_abort", 32'h1, {31'h0, fetch_abort});
		@(negedge mclk);
		idle();
		prot_enable = 1'b0;
		prot_data_ok = 1'b1;
		prot_fetch_ok = 1'b1;
		wctrl(32'h0);
		facc(32'h10, 32'h0, 1'b1);
		idle();
		dacc(1'b0, 32'h10, 32'h0, 1'b1, -1);
		idle();
		// Data memory sits at a nonzero base
		wctrl(32'h0001_0000);
		dacc(1'b1, 32'h1_0008, 32'h3c3c_0008, 1'b0, 0);
		dacc(1'b0, 32'h1_0008, 32'h3c3c_0008, 1'b0, 1);
		dacc(1'b0, 32'h1_0008, 32'h3c3c_0008, 1'b0, 0);
		idle();
		wctrl(32'h0003_0000);
		dacc(1'b1, 32'h1_000c, 32'hc3c3_000c, 1'b0, 0);
		dacc(1'b0, 32'h1_000c, 32'h0, 1'b1, -1);
		idle();
		wctrl(32'h0001_0000);
		dacc(1'b0, 32'h1_000c, 32'hc3c3_000c, 1'b0, 0);
		idle();
		wctrl(32'h0);
		dacc(1'b0, 32'h1_0008, 32'h0, 1'b1, -1);
		idle();
		conclude();
	end
	initial begin
		repeat (2000) @(posedge mclk);
		num_errors++;
		conclude();
	end
endmodule
